// >>> rtl/utf_delay_timer.sv
// Purpose: Interval timer of unit * 2**exp microseconds.
// Assumes: i_start is a one-cycle pulse; settings read live while counting.
// Notes:   A unit value of zero behaves as one.
`timescale 1ns/1ps
module utf_delay_timer import utf_pkg::*; (
	// Clock and reset
	input  wire logic        i_mclk,
	input  wire logic        i_rst_n,
	// Control
	input  wire logic        i_start,
	input  wire logic [15:0] i_unit,
	input  wire logic [2:0]  i_exp,
	// Result
	output logic             o_done
);
	logic       run_q, run_d;
	logic [7:0] pre_q, pre_d;
	logic [15:0] us_q, us_d;
	logic [7:0] mul_q, mul_d;
	logic       done_d;
	logic       pre_end, us_end, mul_end;
	logic [7:0] mul_last;

	always_comb begin
		mul_last = (8'h01 << i_exp) - 8'h01;
		pre_end  = (pre_q == US_CYCLES - 8'h01);
		us_end   = (({1'b0, us_q} + 17'h00001) >= {1'b0, i_unit});
		mul_end  = (mul_q == mul_last);
		run_d    = run_q;
		pre_d    = pre_q;
		us_d     = us_q;
		mul_d    = mul_q;
		done_d   = 1'b0;
		if (i_start) begin
			run_d = 1'b1;
			pre_d = 8'h00;
			us_d  = 16'h0000;
			mul_d = 8'h00;
		end else if (run_q) begin
			if (!pre_end) begin
				pre_d = pre_q + 8'h01;
			end else begin
				pre_d = 8'h00;
				if (!us_end) begin
					us_d = us_q + 16'h0001;
				end else begin
					us_d = 16'h0000;
					if (!mul_end) begin
						mul_d = mul_q + 8'h01;
					end else begin
						mul_d  = 8'h00;
						run_d  = 1'b0;
						done_d = 1'b1;
					end
				end
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			run_q  <= 1'b0;
			pre_q  <= 8'h00;
			us_q   <= 16'h0000;
			mul_q  <= 8'h00;
			o_done <= 1'b0;
		end else begin
			run_q  <= run_d;
			pre_q  <= pre_d;
			us_q   <= us_d;
			mul_q  <= mul_d;
			o_done <= done_d;
		end
	end

	property p_span;
		@(posedge i_mclk) disable iff (!i_rst_n)
		(run_q && !i_start && pre_end && us_end && mul_end) |=> (o_done && !run_q);
	endproperty
	a_span: assert property (p_span) else $error("timer did not finish at last count");

	property p_pow;
		@(posedge i_mclk) disable iff (!i_rst_n)
		o_done |-> ($past(mul_q) == ((8'h01 << $past(i_exp)) - 8'h01));
	endproperty
	a_pow: assert property (p_pow) else $error("timer multiplier not two to the delay field");
endmodule // utf_delay_timer

// >>> rtl/utf_pkg.sv
// Purpose: Shared constants and types for the under-temperature fault response block.
// Assumes: 200 MHz core clock; command codes are PMBus command bytes.
// Notes:   Linear-format helper is shared by the threshold compare in the core.
package utf_pkg;

	localparam logic [7:0]  CMD_UT_FAULT_THRESHOLD = 8'h53;
	localparam logic [7:0]  CMD_UT_FAULT_ACTION    = 8'h54;
	localparam logic [7:0]  CMD_TIME_UNIT          = 8'hd2;

	localparam int          ACT_RESP_HI  = 7;
	localparam int          ACT_RESP_LO  = 6;
	localparam int          ACT_RETRY_HI = 5;
	localparam int          ACT_RETRY_LO = 3;
	localparam int          ACT_DLY_HI   = 2;
	localparam int          ACT_DLY_LO   = 0;

	localparam logic [7:0]  ACTION_RST    = 8'hc0;
	localparam logic [15:0] THRESHOLD_RST = 16'h07d8;
	localparam logic [15:0] TIME_UNIT_RST = 16'h03e8;

	localparam logic [1:0]  RESP_IGNORE  = 2'h0;
	localparam logic [1:0]  RESP_DELAY   = 2'h1;
	localparam logic [1:0]  RESP_RETRY   = 2'h2;
	localparam logic [1:0]  RESP_LATCH   = 2'h3;
	localparam logic [2:0]  RETRY_NONE   = 3'h0;
	localparam logic [2:0]  RETRY_FOREVER = 3'h7;

	// One time-unit step of the 0xD2 register is one microsecond.
	localparam int          CLK_PERIOD_PS = 5000;
	localparam int          TIME_BASE_NS  = 1000;
	localparam logic [7:0]  US_CYCLES     = 8'((TIME_BASE_NS * 1000) / CLK_PERIOD_PS);

	typedef enum logic [2:0] {ST_OFF, ST_RUN, ST_DELAY, ST_WAIT, ST_TRY, ST_LATCH} utf_state_t;

	// Linear11 to signed fixed point with 16 fraction bits; exponent -16..15 maps to shift 0..31.
	function automatic logic signed [47:0] lin_to_fix(input logic [15:0] v);
		logic signed [47:0] m;
		logic        [4:0]  sh;
		m  = {{37{v[10]}}, v[10:0]};
		sh = v[15:11] + 5'h10;
		lin_to_fix = m <<< sh;
	endfunction

endpackage

// >>> rtl/utf_sync.sv
// Purpose: Two-flop synchroniser for a level arriving from a pin.
// Assumes: Input changes slowly compared to the clock.
// Notes:   Only the second flop is visible outside.
`timescale 1ns/1ps
module utf_sync import utf_pkg::*; (
	// Clock and reset
	input  wire logic i_mclk,
	input  wire logic i_rst_n,
	// Level
	input  wire logic i_d,
	output logic      o_q
);
	logic meta_q;

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_q <= 1'b0;
			o_q    <= 1'b0;
		end else begin
			meta_q <= i_d;
			o_q    <= meta_q;
		end
	end
endmodule // utf_sync

// >>> rtl/utf_undertemp_fault.sv
// Purpose: Under-temperature fault response: ignore, delay, retry or latch off.
// Assumes: i_temp and i_oper_on come from logic on i_mclk; pins pass a synchroniser.
// Notes:   Command port writes take effect on the next edge; reads return one edge later.
// Functional notes
// - Response 00 keeps regulating through an under-temperature fault.
// - Response 01 runs for the delay, then follows retries if fault remains.
// - Response 10 disables output at once, then follows the retry field bits 5:3.
// - Response 11 disables output until a clearing event.
// - Latch clears on bit clear, CLEAR_FAULTS, reset, off-then-on, or bias loss.
// - Retry field 000 makes no restart; output stays off until cleared.
// - Retry 1 to 6 attempts that many restarts, then stays off until cleared.
// - Starts of consecutive restart attempts are one delay interval apart.
// - Retry 111 retries forever until commanded off, bias lost, or other fault.
// - Delay field gives a multiplier of two to its value, 1 to 128 units.
// - One delay unit comes from the timing register at command 0xD2.
// - Fault threshold is a 16-bit linear value at command 0x53.
`timescale 1ns/1ps
module utf_undertemp_fault import utf_pkg::*; (
	// Clock and reset
	input  wire logic        i_mclk,
	input  wire logic        i_rst_n,
	// Command port
	input  wire logic        i_cmd_wr,
	input  wire logic        i_cmd_rd,
	input  wire logic [7:0]  i_cmd_code,
	input  wire logic [15:0] i_cmd_wdata,
	output logic      [15:0] o_cmd_rdata,
	// Fault clearing
	input  wire logic        i_clear_faults,
	input  wire logic        i_fault_bit_clr,
	// On and off control
	input  wire logic        i_ctrl_pin_on,
	input  wire logic        i_oper_on,
	input  wire logic        i_bias_ok,
	input  wire logic        i_other_fault,
	// Measurement
	input  wire logic [15:0] i_temp,
	// Status and output control
	output logic             o_out_en,
	output logic             o_ut_fault,
	output logic             o_retrying
);
	logic        ctrl_s, bias_s;
	logic        on_cmd, ok, clr_evt;
	logic        tdone, tstart;
	logic        below_now;
	logic [1:0]  resp;
	logic [2:0]  retries;
	logic [2:0]  dly;

	logic [7:0]  act_q, act_d;
	logic [15:0] thr_q, thr_d;
	logic [15:0] unit_q, unit_d;
	logic [15:0] rdata_d;

	utf_state_t  state_q, state_d;
	logic [2:0]  left_q, left_d;
	logic        fault_q, fault_d;
	logic        ut_fault_d;
	logic        out_en_d;
	logic        retrying_d;

	utf_sync u_sync_ctrl (
		.i_mclk  (i_mclk),
		.i_rst_n (i_rst_n),
		.i_d     (i_ctrl_pin_on),
		.o_q     (ctrl_s)
	);

	utf_sync u_sync_bias (
		.i_mclk  (i_mclk),
		.i_rst_n (i_rst_n),
		.i_d     (i_bias_ok),
		.o_q     (bias_s)
	);

	utf_delay_timer u_timer (
		.i_mclk  (i_mclk),
		.i_rst_n (i_rst_n),
		.i_start (tstart),
		.i_unit  (unit_q),
		.i_exp   (dly),
		.o_done  (tdone)
	);

	assign resp    = act_q[ACT_RESP_HI:ACT_RESP_LO];
	assign retries = act_q[ACT_RETRY_HI:ACT_RETRY_LO];
	assign dly     = act_q[ACT_DLY_HI:ACT_DLY_LO];
	// Losing the pin, OPERATION or bias all read as a commanded off.
	assign on_cmd  = ctrl_s & i_oper_on & bias_s;
	assign ok      = on_cmd & ~i_other_fault;
	assign clr_evt = i_clear_faults | i_fault_bit_clr;

	// Register file on the command port.
	always_comb begin
		act_d   = act_q;
		thr_d   = thr_q;
		unit_d  = unit_q;
		rdata_d = o_cmd_rdata;
		if (i_cmd_wr) begin
			case (i_cmd_code)
				CMD_UT_FAULT_ACTION:    act_d  = i_cmd_wdata[7:0];
				CMD_UT_FAULT_THRESHOLD: thr_d  = i_cmd_wdata;
				CMD_TIME_UNIT:          unit_d = i_cmd_wdata;
				default:                act_d  = act_q;
			endcase
		end
		if (i_cmd_rd) begin
			case (i_cmd_code)
				CMD_UT_FAULT_ACTION:    rdata_d = {8'h00, act_q};
				CMD_UT_FAULT_THRESHOLD: rdata_d = thr_q;
				CMD_TIME_UNIT:          rdata_d = unit_q;
				default:                rdata_d = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			act_q       <= ACTION_RST;
			thr_q       <= THRESHOLD_RST;
			unit_q      <= TIME_UNIT_RST;
			o_cmd_rdata <= 16'h0000;
		end else begin
			act_q       <= act_d;
			thr_q       <= thr_d;
			unit_q      <= unit_d;
			o_cmd_rdata <= rdata_d;
		end
	end

	// Fault detection and the sticky status bit; a new fault beats a clear in the same cycle.
	always_comb begin
		below_now  = (lin_to_fix(i_temp) < lin_to_fix(thr_q));
		fault_d    = below_now;
		ut_fault_d = fault_q | (o_ut_fault & ~clr_evt);
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			fault_q    <= 1'b0;
			o_ut_fault <= 1'b0;
		end else begin
			fault_q    <= fault_d;
			o_ut_fault <= ut_fault_d;
		end
	end

	// Response sequencer. The output is on through every restart attempt and between them; it is off in the wait before the first.
	always_comb begin
		state_d = state_q;
		left_d  = left_q;
		tstart  = 1'b0;
		if (!on_cmd) begin
			state_d = ST_OFF;
		end else if (i_other_fault) begin
			state_d = ST_LATCH;
		end else begin
			case (state_q)
				ST_OFF: begin
					state_d = ST_RUN;
				end
				ST_RUN: begin
					if (fault_q) begin
						case (resp)
							RESP_IGNORE: state_d = ST_RUN;
							RESP_DELAY: begin
								state_d = ST_DELAY;
								tstart  = 1'b1;
							end
							RESP_RETRY: begin
								state_d = (retries == RETRY_NONE) ? ST_LATCH : ST_WAIT;
								left_d  = retries;
								tstart  = 1'b1;
							end
							default: state_d = ST_LATCH;
						endcase
					end
				end
				ST_DELAY: begin
					if (!fault_q) begin
						state_d = ST_RUN;
					end else if (tdone) begin
						state_d = (retries == RETRY_NONE) ? ST_LATCH : ST_WAIT;
						left_d  = retries;
						tstart  = 1'b1;
					end
				end
				ST_WAIT, ST_TRY: begin
					if (state_q == ST_TRY && !fault_q) begin
						state_d = ST_RUN;
					end else if (tdone) begin
						if (retries == RETRY_FOREVER || left_q != 3'h0) begin
							state_d = ST_TRY;
							tstart  = 1'b1;
							if (retries != RETRY_FOREVER) begin
								left_d = left_q - 3'h1;
							end
						end else begin
							state_d = ST_LATCH;
						end
					end
				end
				ST_LATCH: begin
					if (clr_evt) begin
						state_d = ST_RUN;
					end
				end
				default: state_d = ST_OFF;
			endcase
		end
		out_en_d   = (state_d == ST_RUN) || (state_d == ST_DELAY) || (state_d == ST_TRY);
		retrying_d = (state_d == ST_WAIT) || (state_d == ST_TRY);
	end

	always_ff @(posedge i_mclk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_q    <= ST_OFF;
			left_q     <= 3'h0;
			o_out_en   <= 1'b0;
			o_retrying <= 1'b0;
		end else begin
			state_q    <= state_d;
			left_q     <= left_d;
			o_out_en   <= out_en_d;
			o_retrying <= retrying_d;
		end
	end

	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);

	property p_ignore;
		(state_q == ST_RUN && resp == RESP_IGNORE && fault_q && ok) |=> (state_q == ST_RUN && o_out_en);
	endproperty
	a_ignore: assert property (p_ignore) else $error("ignored fault changed operation");

	property p_delay_end;
		(state_q == ST_DELAY && fault_q && tdone && ok && retries != RETRY_NONE)
			|=> (state_q == ST_WAIT && !o_out_en);
	endproperty
	a_delay_end: assert property (p_delay_end) else $error("delay expiry did not shut down");

	property p_delay_keep;
		(state_q == ST_RUN && resp == RESP_DELAY && fault_q && ok) |=> (o_out_en ##1 (o_out_en || !ok || tdone));
	endproperty
	a_delay_keep: assert property (p_delay_keep) else $error("output dropped during delay");

	property p_shut;
		(state_q == ST_RUN && resp == RESP_RETRY && fault_q && ok && retries != RETRY_NONE)
			|=> (state_q == ST_WAIT && !o_out_en && o_retrying && left_q == $past(retries));
	endproperty
	a_shut: assert property (p_shut) else $error("disable and retry did not shut down");

	property p_latch;
		(state_q == ST_RUN && resp == RESP_LATCH && fault_q && ok) |=> (state_q == ST_LATCH && !o_out_en);
	endproperty
	a_latch: assert property (p_latch) else $error("latch response did not latch off");

	property p_hold;
		(state_q == ST_LATCH && on_cmd && !clr_evt) |=> (state_q == ST_LATCH && !o_out_en);
	endproperty
	a_hold: assert property (p_hold) else $error("latched fault released without clear");

	property p_clear;
		(state_q == ST_LATCH && ok && clr_evt) |=> (state_q == ST_RUN && o_out_en);
	endproperty
	a_clear: assert property (p_clear) else $error("clear did not release latch");

	property p_off;
		!on_cmd |=> (state_q == ST_OFF && !o_out_en && !o_retrying);
	endproperty
	a_off: assert property (p_off) else $error("off command not obeyed");

	property p_noretry;
		(state_q == ST_RUN && resp == RESP_RETRY && fault_q && ok && retries == RETRY_NONE)
			|=> (state_q == ST_LATCH && !o_out_en);
	endproperty
	a_noretry: assert property (p_noretry) else $error("zero retries restarted");

	property p_finite;
		(state_q == ST_TRY && fault_q && tdone && ok && left_q == 3'h0 && retries != RETRY_FOREVER)
			|=> (state_q == ST_LATCH && !o_out_en);
	endproperty
	a_finite: assert property (p_finite) else $error("retries exceeded programmed count");

	property p_forever;
		(state_q == ST_TRY && fault_q && tdone && ok && retries == RETRY_FOREVER)
			|=> (state_q == ST_TRY && o_out_en && left_q == $past(left_q));
	endproperty
	a_forever: assert property (p_forever) else $error("continuous retry stopped");

	property p_fault;
		below_now |-> ##2 o_ut_fault;
	endproperty
	a_fault: assert property (p_fault) else $error("under-temperature not flagged");

	c_retry_ok:  cover property (state_q == ST_TRY ##1 state_q == ST_RUN);
	c_give_up:   cover property (state_q == ST_TRY ##1 state_q == ST_LATCH);
	c_delay_ok:  cover property (state_q == ST_DELAY ##1 state_q == ST_RUN);
	c_off_clear: cover property (state_q == ST_LATCH ##1 state_q == ST_OFF);
endmodule // utf_undertemp_fault

// >>> sim/testbench.sv
// Purpose: Self-checking bench for the under-temperature fault response block.
// Assumes: Time unit register is set to 1 so one interval is 200 cycles.
// Notes:   Interval checks allow a few cycles for synchronisers and timer start.
`timescale 1ns/1ps
module testbench;
	import utf_pkg::*;
	localparam logic [15:0] COLD = 16'h07ce;
	localparam logic [15:0] WARM = 16'h0019;
	localparam int          IV   = 200;
	logic        clk = 1'b0, rst_n = 1'b0, pin_on = 1'b1, bias_ok = 1'b1, other_fault = 1'b0;
	logic        cmd_wr, cmd_rd, clr, bclr, oper_on, out_en, ut_fault, retrying;
	logic [7:0]  cmd_code;
	logic [15:0] wdata, rdata, rv, temp = 16'h0019;
	int          mismatches = 0, n_tests = 0, n, r, d;
	logic [7:0]  codes [4] = '{8'h54, 8'h53, 8'hd2, 8'h55};
	logic [15:0] rstv [4]  = '{16'h00c0, 16'h07d8, 16'h03e8, 16'h0000};
	logic [7:0]  acts [3]  = '{8'h80, 8'h91, 8'hb0};

	always #2.5 clk = ~clk;

	utf_host_model utf_host_model_i (.i_mclk(clk), .o_cmd_wr(cmd_wr), .o_cmd_rd(cmd_rd), .o_cmd_code(cmd_code),
		.o_cmd_wdata(wdata), .i_cmd_rdata(rdata), .o_clear_faults(clr), .o_fault_bit_clr(bclr),
		.o_oper_on(oper_on));
	utf_undertemp_fault utf_undertemp_fault_i (.i_mclk(clk), .i_rst_n(rst_n), .i_cmd_wr(cmd_wr),
		.i_cmd_rd(cmd_rd), .i_cmd_code(cmd_code), .i_cmd_wdata(wdata), .o_cmd_rdata(rdata),
		.i_clear_faults(clr), .i_fault_bit_clr(bclr), .i_ctrl_pin_on(pin_on), .i_oper_on(oper_on),
		.i_bias_ok(bias_ok), .i_other_fault(other_fault), .i_temp(temp), .o_out_en(out_en),
		.o_ut_fault(ut_fault), .o_retrying(retrying));

	task automatic final_report();
		if (mismatches == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic chk_rng(input string what, input int v, input int lo, input int hi);
		check(what, 16'(v), (v >= lo && v <= hi) ? 16'(v) : 16'(lo));
	endtask

	// Bounded wait on out_en (sel 0) or retrying (sel 1); cnt is the cycles spent.
	task automatic wait_for(input int sel, input logic v, input int lim, output int cnt);
		cnt = 0;
		// Callers may arrive in the time step of an edge; let its updates settle first.
		#1;
		while (cnt < lim && (sel == 0 ? out_en : retrying) !== v) begin
			@(posedge clk);
			#1;
			cnt++;
		end
	endtask

	task automatic set_temp(input logic [15:0] t);
		@(posedge clk);
		temp <= t;
		#1;
	endtask

	task automatic recover();
		set_temp(WARM);
		utf_host_model_i.pulse(1'b0);
		wait_for(0, 1'b1, 12, n);
		check("out_en after clear", 16'(out_en), 16'h1);
	endtask

	initial begin
		repeat (40000) @(posedge clk);
		mismatches++;
		final_report();
	end

	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk);
		#1;
		check("out_en after reset", 16'(out_en), 16'h1);
		for (int i = 0; i < 4; i++) begin
			utf_host_model_i.rd(codes[i], rv);
			check("reset value", rv, rstv[i]);
		end
		utf_host_model_i.wr(8'h55, 16'h1234);
		utf_host_model_i.rd(8'h55, rv);
		check("unmapped code", rv, 16'h0000);
		utf_host_model_i.wr(8'h54, 16'hff91);
		utf_host_model_i.rd(8'h54, rv);
		check("action byte", rv, 16'h0091);
		utf_host_model_i.wr(8'hd2, 16'h0001);
		utf_host_model_i.rd(8'hd2, rv);
		check("time unit", rv, 16'h0001);
		utf_host_model_i.wr(8'h53, 16'h07d9);
		utf_host_model_i.rd(8'h53, rv);
		check("threshold", rv, 16'h07d9);

		// Ignore response; also probes the threshold boundary.
		utf_host_model_i.wr(8'h54, 16'h0000);
		// Probes use a negative exponent against the whole-degree threshold written above.
		set_temp(16'hffb2);
		repeat (10) @(posedge clk);
		#1;
		check("fault at threshold", 16'(ut_fault), 16'h0);
		set_temp(16'hffb1);
		repeat (20) @(posedge clk);
		#1;
		check("fault below threshold", 16'(ut_fault), 16'h1);
		check("ignore keeps output", 16'(out_en), 16'h1);
		recover();
		check("status cleared", 16'(ut_fault), 16'h0);

		// Latch off, then each clearing event in turn.
		utf_host_model_i.wr(8'h54, 16'h00c0);
		for (int ev = 0; ev < 6; ev++) begin
			set_temp(COLD);
			wait_for(0, 1'b0, 4, n);
			chk_rng("latch shutdown", n, 0, 3);
			set_temp(WARM);
			repeat (300) @(posedge clk);
			#1;
			check("latched off", 16'(out_en), 16'h0);
			case (ev)
				0: utf_host_model_i.pulse(1'b0);
				1: utf_host_model_i.pulse(1'b1);
				2: begin
					utf_host_model_i.oper(1'b0);
					repeat (8) @(posedge clk);
					utf_host_model_i.oper(1'b1);
				end
				3: begin
					@(posedge clk);
					bias_ok <= 1'b0;
					repeat (8) @(posedge clk);
					bias_ok <= 1'b1;
				end
				4: begin
					@(posedge clk);
					rst_n <= 1'b0;
					repeat (2) @(posedge clk);
					rst_n <= 1'b1;
					utf_host_model_i.wr(8'hd2, 16'h0001);
					utf_host_model_i.wr(8'h53, 16'h07d9);
				end
				default: begin
					@(posedge clk);
					pin_on <= 1'b0;
					repeat (8) @(posedge clk);
					pin_on <= 1'b1;
				end
			endcase
			wait_for(0, 1'b1, 12, n);
			check("out_en after clear event", 16'(out_en), 16'h1);
		end

		// Disable and retry with 0, 2 and 6 attempts.
		for (int k = 0; k < 3; k++) begin
			r = int'(acts[k][5:3]);
			d = IV << acts[k][2:0];
			utf_host_model_i.wr(8'h54, {8'h00, acts[k]});
			set_temp(COLD);
			wait_for(0, 1'b0, 4, n);
			chk_rng("retry shutdown", n, 0, 3);
			if (r > 0) begin
				wait_for(0, 1'b1, d + 10, n);
				chk_rng("first restart", n, d - 4, d + 4);
			end
			wait_for(1, 1'b0, r * d + 20, n);
			chk_rng("retries used", n, r * d - 8, r * d + 8);
			repeat (2 * IV) @(posedge clk);
			#1;
			check("off after retries", 16'(out_en), 16'h0);
			recover();
		end

		// Keep running for the delay: the fault goes away, then no retry, then one retry.
		utf_host_model_i.wr(8'h54, 16'h0040);
		set_temp(COLD);
		repeat (IV / 2) @(posedge clk);
		set_temp(WARM);
		wait_for(0, 1'b0, 2 * IV, n);
		check("fault gone in delay", 16'(out_en), 16'h1);
		for (int k = 0; k < 2; k++) begin
			utf_host_model_i.wr(8'h54, (k == 1) ? 16'h0048 : 16'h0040);
			set_temp(COLD);
			wait_for(0, 1'b0, IV + 20, n);
			chk_rng("run through delay", n, IV - 4, IV + 6);
			if (k == 1) begin
				wait_for(0, 1'b1, IV + 10, n);
				chk_rng("restart after delay", n, IV - 4, IV + 4);
				wait_for(1, 1'b0, IV + 20, n);
				chk_rng("retry after delay", n, IV - 8, IV + 8);
			end
			repeat (2 * IV) @(posedge clk);
			#1;
			check("off after delay", 16'(out_en), 16'h0);
			recover();
		end

		// Endless retry stops on another fault or when commanded off.
		utf_host_model_i.wr(8'h54, 16'h00b8);
		set_temp(COLD);
		repeat (8 * IV) @(posedge clk);
		#1;
		check("still retrying", 16'(retrying), 16'h1);
		@(posedge clk);
		other_fault <= 1'b1;
		wait_for(1, 1'b0, 4, n);
		check("other fault stops retry", 16'(retrying), 16'h0);
		check("other fault output off", 16'(out_en), 16'h0);
		@(posedge clk);
		other_fault <= 1'b0;
		utf_host_model_i.pulse(1'b1);
		wait_for(1, 1'b1, 8, n);
		check("retry resumes", 16'(retrying), 16'h1);
		@(posedge clk);
		pin_on <= 1'b0;
		wait_for(1, 1'b0, 8, n);
		check("retry stopped", 16'(retrying), 16'h0);
		check("output off", 16'(out_en), 16'h0);
		set_temp(WARM);
		@(posedge clk);
		pin_on <= 1'b1;
		wait_for(0, 1'b1, 12, n);
		check("on again", 16'(out_en), 16'h1);
		final_report();
	end
endmodule // testbench

// >>> sim/utf_host_model.sv
// Purpose: Behavioural PMBus host that programs, reads and clears the fault block.
// Assumes: Command strobes are one-cycle pulses sampled on the rising edge of i_mclk.
// Notes:   The testbench calls the tasks hierarchically; OPERATION is a level held here.
`timescale 1ns/1ps
module utf_host_model (
	// Clock
	input  wire logic        i_mclk,
	// Command port
	output logic             o_cmd_wr,
	output logic             o_cmd_rd,
	output logic [7:0]       o_cmd_code,
	output logic [15:0]      o_cmd_wdata,
	input  wire logic [15:0] i_cmd_rdata,
	// Clearing and OPERATION
	output logic             o_clear_faults,
	output logic             o_fault_bit_clr,
	output logic             o_oper_on
);
	initial begin
		o_cmd_wr        = 1'b0;
		o_cmd_rd        = 1'b0;
		o_cmd_code      = 8'h00;
		o_cmd_wdata     = 16'h0000;
		o_clear_faults  = 1'b0;
		o_fault_bit_clr = 1'b0;
		o_oper_on       = 1'b1;
	end

	task automatic wr(input logic [7:0] code, input logic [15:0] data);
		@(posedge i_mclk);
		o_cmd_wr    <= 1'b1;
		o_cmd_code  <= code;
		o_cmd_wdata <= data;
		@(posedge i_mclk);
		o_cmd_wr <= 1'b0;
	endtask

	// Read data is registered one edge after the strobe, so one more edge is let pass.
	task automatic rd(input logic [7:0] code, output logic [15:0] data);
		@(posedge i_mclk);
		o_cmd_rd   <= 1'b1;
		o_cmd_code <= code;
		@(posedge i_mclk);
		o_cmd_rd <= 1'b0;
		@(posedge i_mclk);
		#1 data = i_cmd_rdata;
	endtask

	task automatic pulse(input logic bit_clr);
		@(posedge i_mclk);
		if (bit_clr)
			o_fault_bit_clr <= 1'b1;
		else
			o_clear_faults <= 1'b1;
		@(posedge i_mclk);
		o_fault_bit_clr <= 1'b0;
		o_clear_faults  <= 1'b0;
	endtask

	task automatic oper(input logic on);
		@(posedge i_mclk);
		o_oper_on <= on;
	endtask
endmodule // utf_host_model
